// File: common/fan_cfg_pkg.sv
`default_nettype none
package fan_cfg_pkg;

  // register offsets
  localparam logic [7:0] MODULE_MAP_ADDR    = 8'h0F;
  localparam logic [7:0] MODE_RETRY_ADDR    = 8'h10;
  localparam logic [7:0] FAILSAFE_BUS_ADDR  = 8'h11;

  // values after reset, and the mode/retry write mask
  localparam logic [7:0] MODULE_MAP_RESET   = 8'h00;
  localparam logic [7:0] MODE_RETRY_RESET   = 8'h18;
  localparam logic [7:0] FAILSAFE_BUS_RESET = 8'h04;
  localparam logic [7:0] MODE_RETRY_WMASK   = 8'h7F;

  // field positions in the mode/retry register
  localparam int RETRY_LSB     = 3;
  localparam int SKIP_PULSE    = 5;
  localparam int CORE_LOW_BIT  = 6;
  // field positions in the failsafe/bus register
  localparam int HYST_BIT      = 0;
  localparam int FORCE_MAX_BIT = 1;
  localparam int TERM_V_BIT    = 2;
  localparam int TIMED_SPIN    = 3;
  localparam int TIMEOUT_DIS   = 4;
  localparam int FAILSAFE_LSB  = 5;
  localparam int EXT_HYST_BIT  = 2;

  // timing, and the slave error limit
  localparam int CLK_MHZ        = 100;
  localparam int RETRY_BASE_MS  = 1;
  localparam int RETRY_BASE_CYC = RETRY_BASE_MS * CLK_MHZ * 1000;
  localparam int BUS_TIMEOUT_MS = 35;
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam logic [1:0] ERR_LIMIT = 2'h3;

  typedef struct packed {
    logic       we;
    logic       lock;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] module_map;
    logic [2:0] lut_mode;
    logic [1:0] retry_sel;
    logic       skip_first;
    logic       core_low_en;
    logic       hyst_en;
    logic       force_max;
    logic       term_v_en;
    logic       timed_spin;
    logic       timeout_dis;
    logic [2:0] failsafe_en;
  } cfg_s;

endpackage
`default_nettype wire

// File: hdl/retry_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts a retry interval of 1, 2, 4 or 8 base periods, then pulses done
module retry_timer #(
  parameter int BASE_CYC = fan_cfg_pkg::RETRY_BASE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [1:0] sel,
  output logic            busy,
  output logic            done
);
  logic [23:0] cnt;
  logic [3:0]  periods;

  // period count latched at start so a later register write cannot stretch it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt     <= 24'h000000;
      periods <= 4'h0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy    <= 1'b1;
        cnt     <= 24'(BASE_CYC - 1);
        periods <= 4'(4'h1 << sel) - 4'h1;
      end else if (busy) begin
        if (cnt != 24'h000000) begin
          cnt <= cnt - 24'h000001;
        end else if (periods != 4'h0) begin
          periods <= periods - 4'h1;
          cnt     <= 24'(BASE_CYC - 1);
        end else begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/fan_monitor_config_regs.sv
// How it works
// - four 2-bit fields map memory modules 0..3 to processors 0..3, low bits first.
// - bits 0-2 pick per-fan control law: 0 temperature range, 1 lookup table.
// - retry field bits 4:3 gives master retry wait of 1, 2, 4 or 8 ms.
// - a failed master read is retried on the same slave after that wait.
// - with skip bit set, the first speed pulse of each measurement is dropped.
// - core-low mode plus low core voltage sets status, alert, stops hot monitoring.
// - core voltage recovery resumes hot monitoring and pulses fan spin-up in the same cycle.
// - overtemp hysteresis only when own bit 0 set and external bit clear.
// - force bit drives every fan at its maximum duty register value.
// - the force bit ignores the register lock and is always writable.
// - bit 2 includes the termination voltage channel in the monitoring sweep.
// - timed spin-up bit holds outputs high for the full spin-up timeout.
// - bit 4 set disables the 35 ms bus lock-up timeout; the bit is lockable.
// - per-fan bits 5-7 force full speed after three straight slave errors.
`timescale 1ns/1ps
`default_nettype none
module fan_monitor_config_regs (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire fan_cfg_pkg::reg_req_s req,
  output logic [7:0]                 rdata,
  output fan_cfg_pkg::cfg_s          cfg,
  // monitoring status inputs from same-clock logic
  input  wire logic                  core_below_low,
  input  wire logic                  ext_hyst_disable,
  input  wire logic                  tach_pulse,
  input  wire logic                  tach_meas_start,
  input  wire logic                  master_read_error,
  input  wire logic                  master_read_ok,
  input  wire logic [1:0]            slave_index,
  output logic                       tach_pulse_counted,
  output logic                       master_retry_go,
  output logic                       master_retry_wait,
  output logic                       core_low_status,
  output logic                       core_low_alert,
  output logic                       processor_hot_enable,
  output logic                       spinup_request,
  output logic                       overtemp_output_hysteresis_en,
  output logic                       term_v_in_sweep,
  output logic                       bus_timeout_active,
  output logic [2:0]                 fan_force_max,
  output logic [2:0]                 fan_force_full
);
  logic [7:0] module_map;
  logic [7:0] mode_retry;
  logic [7:0] failsafe_bus;
  logic       skip_pending;
  logic       core_low_seen;
  logic [1:0] err_cnt [4];
  logic       failsafe_trip;
  logic       wr_map, wr_mode, wr_fs;

  // address decode shared by writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  assign wr_map  = req.we && hit(req.addr, fan_cfg_pkg::MODULE_MAP_ADDR);
  assign wr_mode = req.we && hit(req.addr, fan_cfg_pkg::MODE_RETRY_ADDR);
  assign wr_fs   = req.we && hit(req.addr, fan_cfg_pkg::FAILSAFE_BUS_ADDR);

  // module map register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      module_map <= fan_cfg_pkg::MODULE_MAP_RESET;
    end else if (wr_map) begin
      module_map <= req.wdata;
    end
  end

  // mode/retry register, bit 7 reserved and reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_retry <= fan_cfg_pkg::MODE_RETRY_RESET;
    end else if (wr_mode) begin
      mode_retry <= req.wdata & fan_cfg_pkg::MODE_RETRY_WMASK;
    end
  end

  // failsafe/bus register: lock freezes all bits except the force bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      failsafe_bus <= fan_cfg_pkg::FAILSAFE_BUS_RESET;
    end else if (wr_fs) begin
      if (req.lock) begin
        failsafe_bus[fan_cfg_pkg::FORCE_MAX_BIT] <=
          req.wdata[fan_cfg_pkg::FORCE_MAX_BIT];
      end else begin
        failsafe_bus <= req.wdata;
      end
    end
  end

  // read data registered so the data output comes from flip-flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (hit(req.addr, fan_cfg_pkg::MODULE_MAP_ADDR)) begin
      rdata <= module_map;
    end else if (hit(req.addr, fan_cfg_pkg::MODE_RETRY_ADDR)) begin
      rdata <= mode_retry;
    end else if (hit(req.addr, fan_cfg_pkg::FAILSAFE_BUS_ADDR)) begin
      rdata <= failsafe_bus;
    end else begin
      rdata <= 8'h00;
    end
  end

  // decoded configuration to the fan, tach and bus engines
  always_comb begin
    cfg.module_map  = module_map;
    cfg.lut_mode    = mode_retry[2:0];
    cfg.retry_sel   = mode_retry[fan_cfg_pkg::RETRY_LSB +: 2];
    cfg.skip_first  = mode_retry[fan_cfg_pkg::SKIP_PULSE];
    cfg.core_low_en = mode_retry[fan_cfg_pkg::CORE_LOW_BIT];
    cfg.hyst_en     = failsafe_bus[fan_cfg_pkg::HYST_BIT];
    cfg.force_max   = failsafe_bus[fan_cfg_pkg::FORCE_MAX_BIT];
    cfg.term_v_en   = failsafe_bus[fan_cfg_pkg::TERM_V_BIT];
    cfg.timed_spin  = failsafe_bus[fan_cfg_pkg::TIMED_SPIN];
    cfg.timeout_dis = failsafe_bus[fan_cfg_pkg::TIMEOUT_DIS];
    cfg.failsafe_en = failsafe_bus[fan_cfg_pkg::FAILSAFE_LSB +: 3];
  end

  assign overtemp_output_hysteresis_en = cfg.hyst_en && !ext_hyst_disable;
  assign term_v_in_sweep    = cfg.term_v_en;
  assign bus_timeout_active = !cfg.timeout_dis;
  assign fan_force_max      = {3{cfg.force_max}};

  // first tach pulse after a measurement start is swallowed when enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      skip_pending <= 1'b0;
    end else if (tach_meas_start) begin
      skip_pending <= cfg.skip_first;
    end else if (tach_pulse) begin
      skip_pending <= 1'b0;
    end
  end
  assign tach_pulse_counted = tach_pulse && !tach_meas_start && !skip_pending;

  // retry timer: a master read error while the timer is idle starts the programmed wait; errors during a wait are ignored
  retry_timer u_retry (
    .clk   (clk),
    .rst_n (rst_n),
    .start (master_read_error),
    .sel   (cfg.retry_sel),
    .busy  (master_retry_wait),
    .done  (master_retry_go)
  );

  // core-low tracking; the spin-up pulse marks recovery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_low_seen  <= 1'b0;
      spinup_request <= 1'b0;
    end else begin
      spinup_request <= 1'b0;
      if (cfg.core_low_en && core_below_low) begin
        core_low_seen <= 1'b1;
      end else if (core_low_seen && !core_below_low) begin
        core_low_seen  <= 1'b0;
        spinup_request <= 1'b1;
      end
    end
  end
  assign core_low_status      = core_low_seen;
  assign core_low_alert       = core_low_seen;
  assign processor_hot_enable = !core_low_seen;

  // per-slave consecutive error counts, saturating at the limit
  generate
    for (genvar i = 0; i < 4; i++) begin : g_err
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          err_cnt[i] <= 2'h0;
        end else if (slave_index == 2'(i)) begin
          if (master_read_ok) begin
            err_cnt[i] <= 2'h0;
          end else if (master_read_error && err_cnt[i] != fan_cfg_pkg::ERR_LIMIT) begin
            err_cnt[i] <= err_cnt[i] + 2'h1;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    failsafe_trip = 1'b0;
    for (int k = 0; k < 4; k++) begin
      failsafe_trip = failsafe_trip || (err_cnt[k] == fan_cfg_pkg::ERR_LIMIT);
    end
  end
  assign fan_force_full = cfg.failsafe_en & {3{failsafe_trip}};

  // assertions
  // measurement armed while the skip bit is set
  sequence meas_armed_s;
    tach_meas_start && mode_retry[fan_cfg_pkg::SKIP_PULSE];
  endsequence

  force_unlocked_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fs |=> failsafe_bus[1] == $past(req.wdata[1]))
    else $error("force bit write lost");
  lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_fs && req.lock) |=> failsafe_bus[4] == $past(failsafe_bus[4]))
    else $error("locked timeout bit changed");
  hyst_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    overtemp_output_hysteresis_en == (failsafe_bus[0] && !ext_hyst_disable))
    else $error("hysteresis gating wrong");
  err_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    master_read_ok |=> err_cnt[$past(slave_index)] == 2'h0)
    else $error("error count not cleared");
  failsafe_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
    (master_read_error && !master_read_ok && err_cnt[slave_index] == 2'h2) |=> failsafe_trip)
    else $error("third error did not trip failsafe");
  core_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_retry[6] && core_below_low) |=> !processor_hot_enable && core_low_status)
    else $error("core low not handled");
  recover_a: assert property (@(posedge clk) disable iff (!rst_n)
    (core_low_seen && !core_below_low && !(mode_retry[6] && core_below_low))
      |=> spinup_request && processor_hot_enable)
    else $error("recovery missing spin-up");
  skip_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    meas_armed_s ##1 (tach_pulse && !tach_meas_start)
      |-> !tach_pulse_counted)
    else $error("first pulse counted");
  retry_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (master_read_error && !master_retry_wait) |=> master_retry_wait)
    else $error("retry wait not started");
endmodule
`default_nettype wire

// File: dv/fan_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host on the register port: one-cycle write strobes, reads wait for registered data
module fan_host_model (
  input  wire logic                  clk,
  input  wire logic [7:0]            rdata,
  output var  fan_cfg_pkg::reg_req_s req
);
  initial req = '0;
  // the strobe stands for exactly one edge, so a write is never taken twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic lk);
    @(posedge clk);
    req <= '{we: 1'b1, lock: lk, addr: a, wdata: d};
    @(posedge clk);
    req.we <= 1'b0;
  endtask
  // read data is registered one edge after the address moves; taken once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// File: dv/fan_monitor_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fan_monitor_config_regs_tb_top;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  fan_cfg_pkg::reg_req_s req;
  fan_cfg_pkg::cfg_s     cfg;
  logic [7:0]            rdata, d;
  logic                  core_below_low = 1'b0, ext_hyst_disable = 1'b0, tach_pulse = 1'b0;
  logic                  tach_meas_start = 1'b0, master_read_error = 1'b0;
  logic                  master_read_ok = 1'b0;
  logic [1:0]            slave_index = 2'h0;
  logic                  tach_pulse_counted, master_retry_go, master_retry_wait;
  logic                  core_low_status, core_low_alert, processor_hot_enable;
  logic                  spinup_request, hyst_en, term_v_in_sweep, bus_timeout_active;
  logic [2:0]            fan_force_max, fan_force_full;
  int                    failures = 0, checks_done = 0, cyc = 0, n;

  always #5 clk = ~clk;

  fan_host_model u_fan_host_model (.clk(clk), .rdata(rdata), .req(req));

  fan_monitor_config_regs u_fan_monitor_config_regs (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .cfg(cfg),
    .core_below_low(core_below_low), .ext_hyst_disable(ext_hyst_disable),
    .tach_pulse(tach_pulse), .tach_meas_start(tach_meas_start),
    .master_read_error(master_read_error), .master_read_ok(master_read_ok),
    .slave_index(slave_index), .tach_pulse_counted(tach_pulse_counted),
    .master_retry_go(master_retry_go), .master_retry_wait(master_retry_wait),
    .core_low_status(core_low_status), .core_low_alert(core_low_alert),
    .processor_hot_enable(processor_hot_enable), .spinup_request(spinup_request),
    .overtemp_output_hysteresis_en(hyst_en), .term_v_in_sweep(term_v_in_sweep),
    .bus_timeout_active(bus_timeout_active), .fan_force_max(fan_force_max),
    .fan_force_full(fan_force_full)
  );

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // wait k rising edges, then 1 ns so outputs have settled before a check
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic t_regs();
    u_fan_host_model.rd(8'h0F, d); chk("map_rst", d, 8'h00);
    u_fan_host_model.rd(8'h10, d); chk("mode_rst", d, 8'h18);
    u_fan_host_model.rd(8'h11, d); chk("fs_rst", d, 8'h04);
    u_fan_host_model.rd(8'h12, d); chk("unmapped", d, 8'h00);
    u_fan_host_model.wr(8'h0F, 8'hE4, 1'b0);
    u_fan_host_model.rd(8'h0F, d); chk("map", d, 8'hE4);
    chk("mod0", {6'h0, cfg.module_map[1:0]}, 8'h00);
    chk("mod3", {6'h0, cfg.module_map[7:6]}, 8'h03);
    u_fan_host_model.wr(8'h10, 8'hFD, 1'b0);
    u_fan_host_model.rd(8'h10, d); chk("mode_wr", d, 8'h7D);
    chk("law", {5'h0, cfg.lut_mode}, 8'h05);
    $display("test regs done");
  endtask

  // lock leaves only the force bit writable
  task automatic t_lock();
    u_fan_host_model.wr(8'h11, 8'hFF, 1'b1);
    u_fan_host_model.rd(8'h11, d); chk("lock_wr", d, 8'h06);
    chk("force", {5'h0, fan_force_max}, 8'h07);
    chk("tmo_lock", {7'h0, bus_timeout_active}, 8'h01);
    u_fan_host_model.wr(8'h11, 8'h00, 1'b1);
    tick(); chk("force_off", {5'h0, fan_force_max}, 8'h00);
    $display("test lock done");
  endtask

  task automatic t_bits();
    for (int i = 0; i < 8; i++) begin
      u_fan_host_model.wr(8'h11, {3'h0, i[2], i[0], i[1], 1'b0, i[0]}, 1'b0);
      ext_hyst_disable <= i[2];
      tick(2);
      chk("hyst", {7'h0, hyst_en}, {7'h0, i[0] & ~i[2]});
      chk("term", {7'h0, term_v_in_sweep}, {7'h0, i[1]});
      chk("tmo", {7'h0, bus_timeout_active}, {7'h0, ~i[2]});
      chk("spin", {7'h0, cfg.timed_spin}, {7'h0, i[0]});
    end
    $display("test bits done");
  endtask

  task automatic err(input logic ok);
    @(posedge clk);
    if (ok) master_read_ok <= 1'b1;
    else master_read_error <= 1'b1;
    @(posedge clk);
    master_read_ok <= 1'b0;
    master_read_error <= 1'b0;
  endtask

  // two errors, a good read, two more: the count must have restarted
  task automatic t_failsafe();
    u_fan_host_model.wr(8'h11, 8'hA0, 1'b0);
    slave_index <= 2'h1;
    err(0); err(0); err(1); err(0); err(0);
    tick(2); chk("fs_broken", {5'h0, fan_force_full}, 8'h00);
    err(0);
    tick(2); chk("fs_three", {5'h0, fan_force_full}, 8'h05);
    err(1);
    tick(2); chk("fs_clear", {5'h0, fan_force_full}, 8'h00);
    $display("test failsafe done");
  endtask

  task automatic t_core_tach_retry();
    u_fan_host_model.wr(8'h10, 8'h60, 1'b0);
    core_below_low <= 1'b1;
    tick(3);
    chk("cl_stat", {6'h0, core_low_status, core_low_alert}, 8'h03);
    chk("hot_off", {7'h0, processor_hot_enable}, 8'h00);
    @(posedge clk);
    core_below_low <= 1'b0;
    n = 0;
    for (int i = 0; i < 6; i++) begin
      tick(); n += spinup_request;
    end
    chk("spinup", n[7:0], 8'h01);
    chk("hot_on", {7'h0, processor_hot_enable}, 8'h01);
    @(posedge clk); tach_meas_start <= 1'b1;
    @(posedge clk); tach_meas_start <= 1'b0;
    @(posedge clk); tach_pulse <= 1'b1;
    tick(0); chk("tach1", {7'h0, tach_pulse_counted}, 8'h00);
    tick(); chk("tach2", {7'h0, tach_pulse_counted}, 8'h01);
    @(posedge clk);
    tach_pulse <= 1'b0;
    slave_index <= 2'h2;
    err(0);
    tick(2);
    chk("rt_wait", {6'h0, master_retry_wait, master_retry_go}, 8'h02);
    $display("test core tach retry done");
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, well above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_lock();
    t_bits();
    t_failsafe();
    t_core_tach_retry();
    results();
  end
endmodule
`default_nettype wire
